/* hw/itas_defs.svh */
// Offsets, field positions, reset values and masks of the transmit abort cause block
`ifndef ITAS_DEFS_SVH
`define ITAS_DEFS_SVH
`define ITAS_OFS_SDA_HOLD 32'h5000137C
`define ITAS_OFS_ABRT_SRC 32'h50001380
`define ITAS_OFS_ABRT_CLR 32'h50001354
`define ITAS_RST_SDA_HOLD 16'h0001
`define ITAS_RST_ABRT_SRC 16'h0000
`define ITAS_B_SLVRD 15
`define ITAS_B_SLVARB 14
`define ITAS_B_SLVFLUSH 13
`define ITAS_B_ARBLOST 12
`define ITAS_B_MSTDIS 11
`define ITAS_B_TENRD 10
`define ITAS_B_SBNORS 9
`define ITAS_B_HSNORS 8
`define ITAS_B_SBACK 7
`define ITAS_B_HSACK 6
`define ITAS_B_GCRD 5
`define ITAS_B_GCNACK 4
`define ITAS_B_DATNACK 3
`define ITAS_B_A10_2 2
`define ITAS_B_A10_1 1
`define ITAS_B_A7 0
`define ITAS_CMD_RW_BIT 8
`define ITAS_SLAVE_MASK 16'hE000
`endif

/* hw/itas_link_if.sv */
// Signals between the abort logic and the bus pin sequencer
`timescale 1ns/1ps
interface itas_link_if;
   logic [15:0] hold_count;
   logic drive_low;
   logic tx_active;
   logic own_lost;
   logic scl_level;
   modport core (
      output hold_count,
      output drive_low,
      output tx_active,
      input own_lost,
      input scl_level
   );
   modport pins (
      input hold_count,
      input drive_low,
      input tx_active,
      output own_lost,
      output scl_level
   );
endinterface

/* hw/itas_pin_seq.sv */
// Bus pin sampling, SDA hold delay and bus ownership check
`timescale 1ns/1ps
`include "itas_defs.svh"
module itas_pin_seq (
   // Clock and synchronised reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Core side
   itas_link_if.pins lnk
);
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_prev_q;
   logic [15:0] cnt_q;
   logic oe_q;
   logic lost_q;
   itas_pkg::itas_hold_e st_q;
   logic scl_fall;
   logic scl_rise;

   // Two-flop synchronisers; the first stage feeds only the second
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
         scl_prev_q <= scl_sync_q[1];
      end
   end
   assign scl_fall = scl_prev_q & ~scl_sync_q[1];
   assign scl_rise = ~scl_prev_q & scl_sync_q[1];

   // SDA change waits hold_count cycles after SCL falls
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= itas_pkg::ITAS_HS_IDLE;
         cnt_q <= 16'h0000;
         oe_q <= 1'b0;
      end else begin
         unique case (st_q)
            itas_pkg::ITAS_HS_IDLE: begin
               if (scl_fall && lnk.hold_count > 16'h0001) begin
                  cnt_q <= lnk.hold_count - 16'h0001;
                  st_q <= itas_pkg::ITAS_HS_WAIT;
               end else if (scl_fall) begin
                  oe_q <= lnk.drive_low;
               end
            end
            itas_pkg::ITAS_HS_WAIT: begin
               if (cnt_q == 16'h0001) begin
                  oe_q <= lnk.drive_low;
                  st_q <= itas_pkg::ITAS_HS_IDLE;
               end
               cnt_q <= cnt_q - 16'h0001;
            end
            // Recover from a corrupted state code
            default: begin
               st_q <= itas_pkg::ITAS_HS_IDLE;
            end
         endcase
      end
   end

   // Released line read low at SCL rise means another party owns the bus
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lost_q <= 1'b0;
      end else begin
         lost_q <= scl_rise & lnk.tx_active & (sda_sync_q[1] == oe_q);
      end
   end

   assign lnk.own_lost = lost_q;
   assign lnk.scl_level = scl_sync_q[1];
   assign sda_out = 1'b0;
   assign sda_oe_out = oe_q;
endmodule

/* hw/itas_pkg.sv */
// Types shared by the transmit abort cause block
package itas_pkg;
   // Which byte of a master transfer just had its acknowledge sampled
   typedef enum logic [6:0] {
      ITAS_PH_ADDR7 = 7'h01,
      ITAS_PH_ADDR10_1 = 7'h02,
      ITAS_PH_ADDR10_2 = 7'h04,
      ITAS_PH_DATA = 7'h08,
      ITAS_PH_GCALL = 7'h10,
      ITAS_PH_SBYTE = 7'h20,
      ITAS_PH_HSCODE = 7'h40
   } itas_phase_e;
   // Hold-time sequencer states
   typedef enum logic [1:0] {
      ITAS_HS_IDLE = 2'h1,
      ITAS_HS_WAIT = 2'h2
   } itas_hold_e;
endpackage

/* hw/itas_top.sv */
// Transmit abort cause register, SDA hold register and their Avalon-MM slave
`timescale 1ns/1ps
`include "itas_defs.svh"
module itas_top (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Avalon-MM slave
   input wire logic [31:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Controller configuration levels
   input wire logic master_mode_enable_in,
   input wire logic repeated_start_allow_in,
   input wire logic gc_or_startbyte_request_in,
   input wire logic general_call_vs_startbyte_select_in,
   input wire logic tenbit_addr_in,
   input wire logic highspeed_mode_in,
   // Master side events
   input wire logic mst_start_req_in,
   input wire logic mst_next_read_in,
   input wire logic mst_ack_sample_in,
   input wire logic mst_ack_seen_in,
   input wire itas_pkg::itas_phase_e mst_phase_in,
   input wire logic mst_tx_active_in,
   // Slave side events
   input wire logic slave_read_service_in,
   input wire logic data_cmd_write_in,
   input wire logic [9:0] data_cmd_in,
   input wire logic slv_read_cmd_in,
   input wire logic txfifo_not_empty_in,
   input wire logic slv_tx_active_in,
   // Bit to drive on SDA
   input wire logic sda_drive_low_in,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Abort reporting and the synchronised SCL level
   output logic [15:0] abort_cause_out,
   output logic transmit_abort_event_out,
   output logic master_abort_out,
   output logic slave_abort_out,
   output logic txfifo_flush_out,
   output logic scl_level_out
);
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [15:0] hold_q;
   logic [15:0] abrt_q;
   logic [15:0] set_d;
   logic [15:0] abrt_d;
   logic sb_pend_q;
   logic sb_cause;
   logic req;
   logic accept;
   logic clr_now;
   logic evt_q;
   logic mst_evt_q;
   logic slv_evt_q;
   logic flush_q;
   logic restart_off;
   logic ack_evt;
   logic nack_evt;
   logic mst_lost;
   logic slv_lost;

   itas_link_if lnk ();

   // Address compare used by the read mux and the write and clear decode
   function automatic logic hit(input logic [31:0] addr, input logic [31:0] ofs);
      hit = (addr == ofs);
   endfunction

   // Byte-lane merge for a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      merge16 = r;
   endfunction

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Bus handshake: one wait cycle, so read data is ready before release
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_q;
   assign accept = req & ack_q;

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // Read data captured in the wait cycle and held through acceptance
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read_in && !ack_q) begin
         if (hit(avs_address_in, `ITAS_OFS_SDA_HOLD)) begin
            rdata_q <= {16'h0000, hold_q};
         end else if (hit(avs_address_in, `ITAS_OFS_ABRT_SRC)) begin
            rdata_q <= {16'h0000, abrt_q};
         end else begin
            // Clear register and unmapped addresses read as zero
            rdata_q <= 32'h00000000;
         end
      end
   end
   assign avs_readdata_out = rdata_q;

   // Hold time register, written only on the accepting edge
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= `ITAS_RST_SDA_HOLD;
      end else if (accept && avs_write_in && hit(avs_address_in, `ITAS_OFS_SDA_HOLD)) begin
         hold_q <= merge16(hold_q, avs_writedata_in, avs_byteenable_in);
      end
   end

   // Common clear: an accepted read of the clear register
   assign clr_now = accept & avs_read_in & hit(avs_address_in, `ITAS_OFS_ABRT_CLR);

   // Qualifiers for master start attempts and acknowledge sampling
   assign restart_off = ~repeated_start_allow_in;
   assign ack_evt = mst_ack_sample_in & mst_ack_seen_in;
   assign nack_evt = mst_ack_sample_in & ~mst_ack_seen_in;

   // Ownership loss goes to whichever role is transmitting; both may be
   // active, so each role is tracked on its own
   assign mst_lost = lnk.own_lost & mst_tx_active_in;
   assign slv_lost = lnk.own_lost & slv_tx_active_in;

   // START byte with restart off stays a live cause until software fixes it
   assign sb_cause = restart_off & gc_or_startbyte_request_in &
                     general_call_vs_startbyte_select_in;

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sb_pend_q <= 1'b0;
      end else if (!sb_cause) begin
         sb_pend_q <= 1'b0;
      end else if (mst_start_req_in) begin
         sb_pend_q <= 1'b1;
      end
   end

   // Per-cause set terms, all in one cycle
   always_comb begin
      set_d = 16'h0000;
      // Slave side causes
      set_d[`ITAS_B_SLVRD] = data_cmd_write_in & slave_read_service_in &
                             data_cmd_in[`ITAS_CMD_RW_BIT];
      set_d[`ITAS_B_SLVARB] = slv_lost;
      set_d[`ITAS_B_SLVFLUSH] = slv_read_cmd_in & txfifo_not_empty_in;
      // Arbitration loss from either role
      set_d[`ITAS_B_ARBLOST] = mst_lost | slv_lost;
      // Master start attempts
      set_d[`ITAS_B_MSTDIS] = mst_start_req_in & ~master_mode_enable_in;
      set_d[`ITAS_B_TENRD] = mst_start_req_in & restart_off & tenbit_addr_in &
                             mst_next_read_in;
      set_d[`ITAS_B_SBNORS] = sb_pend_q;
      set_d[`ITAS_B_HSNORS] = mst_start_req_in & restart_off &
                              highspeed_mode_in;
      // Master acknowledge outcomes
      set_d[`ITAS_B_SBACK] = ack_evt & (mst_phase_in == itas_pkg::ITAS_PH_SBYTE);
      set_d[`ITAS_B_HSACK] = ack_evt & highspeed_mode_in &
                             (mst_phase_in == itas_pkg::ITAS_PH_HSCODE);
      set_d[`ITAS_B_GCRD] = ack_evt & mst_next_read_in &
                            (mst_phase_in == itas_pkg::ITAS_PH_GCALL);
      set_d[`ITAS_B_GCNACK] = nack_evt & (mst_phase_in == itas_pkg::ITAS_PH_GCALL);
      set_d[`ITAS_B_DATNACK] = nack_evt & master_mode_enable_in &
                               (mst_phase_in == itas_pkg::ITAS_PH_DATA);
      set_d[`ITAS_B_A10_2] = nack_evt & tenbit_addr_in &
                             (mst_phase_in == itas_pkg::ITAS_PH_ADDR10_2);
      set_d[`ITAS_B_A10_1] = nack_evt & tenbit_addr_in &
                             (mst_phase_in == itas_pkg::ITAS_PH_ADDR10_1);
      set_d[`ITAS_B_A7] = nack_evt & ~tenbit_addr_in &
                          (mst_phase_in == itas_pkg::ITAS_PH_ADDR7);
   end

   // Sticky bits: a new event beats the clear, except bit 9, whose clear
   // wins for one cycle and whose pending cause then sets it again
   always_comb begin
      abrt_d = abrt_q | set_d;
      if (clr_now) begin
         abrt_d = set_d;
         abrt_d[`ITAS_B_SBNORS] = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         abrt_q <= `ITAS_RST_ABRT_SRC;
      end else begin
         abrt_q <= abrt_d;
      end
   end

   // Abort event pulses, only for causes newly appearing
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         evt_q <= 1'b0;
         mst_evt_q <= 1'b0;
         slv_evt_q <= 1'b0;
      end else begin
         evt_q <= |(set_d & ~abrt_q);
         mst_evt_q <= |(set_d & ~abrt_q & ~`ITAS_SLAVE_MASK);
         slv_evt_q <= |(set_d & ~abrt_q & `ITAS_SLAVE_MASK);
      end
   end

   // Stale data flush accompanies the slave flush cause
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         flush_q <= 1'b0;
      end else begin
         flush_q <= set_d[`ITAS_B_SLVFLUSH];
      end
   end

   // Pin sequencer handles hold delay and ownership checks
   assign lnk.hold_count = hold_q;
   assign lnk.drive_low = sda_drive_low_in;
   assign lnk.tx_active = mst_tx_active_in | slv_tx_active_in;

   itas_pin_seq u_pins (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .lnk(lnk)
   );

   // Reporting outputs, all from flops
   assign abort_cause_out = abrt_q;
   assign transmit_abort_event_out = evt_q;
   assign master_abort_out = mst_evt_q;
   assign slave_abort_out = slv_evt_q;
   assign txfifo_flush_out = flush_q;
   assign scl_level_out = lnk.scl_level;
endmodule

/* verif/itas_remote.sv */
// Remote bus party: clocks SCL within frames and may pull SDA low
`timescale 1ns/1ps
module itas_remote (
   // Control from the bench
   input wire logic frame_in,
   input wire logic pull_low_in,
   // Device drive of the open-drain SDA
   input wire logic dev_oe_in,
   // Bus lines seen by the device
   output logic scl_out,
   output logic sda_out
);
   logic scl_q = 1'b1;
   // Half of the 160 ns link period; SCL rests high on its pull-up between frames
   always begin
      #80;
      scl_q = frame_in ? ~scl_q : 1'b1;
   end
   assign scl_out = scl_q;
   // Wired-AND with pull-up, so a remote pull can contradict the device
   assign sda_out = !(dev_oe_in || pull_low_in);
endmodule

/* verif/itas_top_assertions.sv */
// Port-level checks of the transmit abort cause block
`timescale 1ns/1ps
`include "itas_defs.svh"
module itas_checker (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Register bus
   input wire logic [31:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_waitrequest_out,
   // Cause inputs
   input wire logic master_mode_enable_in,
   input wire logic repeated_start_allow_in,
   input wire logic gc_or_startbyte_request_in,
   input wire logic general_call_vs_startbyte_select_in,
   input wire logic tenbit_addr_in,
   input wire logic mst_start_req_in,
   input wire logic mst_ack_sample_in,
   input wire logic mst_ack_seen_in,
   input wire itas_pkg::itas_phase_e mst_phase_in,
   input wire logic slv_read_cmd_in,
   input wire logic txfifo_not_empty_in,
   // Results
   input wire logic [15:0] abort_cause_out,
   input wire logic transmit_abort_event_out,
   input wire logic master_abort_out,
   input wire logic slave_abort_out,
   input wire logic txfifo_flush_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // Clear read taken at this edge; bits may only drop one cycle after it
   wire clr_w = avs_read_in && !avs_waitrequest_out && avs_address_in == `ITAS_OFS_ABRT_CLR;
   // Start-byte request that restart generation cannot serve
   wire sb_w = !repeated_start_allow_in && gc_or_startbyte_request_in
      && general_call_vs_startbyte_select_in;
   bus_one_wait_a: assert property ($rose(avs_read_in) |-> avs_waitrequest_out
      ##1 !avs_waitrequest_out) else $error("read not answered after one wait");
   addr7_nack_a: assert property (
      mst_ack_sample_in && !mst_ack_seen_in && !tenbit_addr_in
      && mst_phase_in == itas_pkg::ITAS_PH_ADDR7 |=> abort_cause_out[0])
      else $error("address nack not recorded");
   mst_disabled_a: assert property (
      mst_start_req_in && !master_mode_enable_in |=> abort_cause_out[11])
      else $error("disabled master start not recorded");
   stale_flush_a: assert property (
      slv_read_cmd_in && txfifo_not_empty_in |=> txfifo_flush_out && abort_cause_out[13])
      else $error("stale fifo flush missing");
   slave_loss_a: assert property (
      $rose(abort_cause_out[14]) |-> abort_cause_out[12])
      else $error("slave loss without arbitration bit");
   sbyte_set_a: assert property (
      mst_start_req_in && sb_w |-> ##[1:2] abort_cause_out[9])
      else $error("start byte without restart not recorded");
   sbyte_back_a: assert property (
      $fell(abort_cause_out[9]) && sb_w |=> abort_cause_out[9])
      else $error("bit 9 not reasserted");
   sticky_bits_a: assert property (
      |($past(abort_cause_out) & ~abort_cause_out) |-> $past(clr_w))
      else $error("abort bit dropped without clear");
   abort_event_a: assert property (
      transmit_abort_event_out == |(abort_cause_out & ~$past(abort_cause_out)))
      else $error("abort event does not match new bits");
   slave_split_a: assert property (
      slave_abort_out == |(abort_cause_out[15:13] & ~$past(abort_cause_out[15:13])))
      else $error("slave abort pulse wrong");
   mst_split_a: assert property (
      master_abort_out == |(abort_cause_out[12:0] & ~$past(abort_cause_out[12:0])))
      else $error("master abort pulse wrong");
   // Main scenarios reached
   cover property (txfifo_flush_out);
   cover property ($rose(abort_cause_out[14]));
   cover property ($fell(abort_cause_out[9]));
endmodule

bind itas_top itas_checker itas_checker_i (.clk_in, .resetn_in, .avs_address_in,
   .avs_read_in, .avs_waitrequest_out, .master_mode_enable_in, .repeated_start_allow_in,
   .gc_or_startbyte_request_in, .general_call_vs_startbyte_select_in, .tenbit_addr_in,
   .mst_start_req_in, .mst_ack_sample_in, .mst_ack_seen_in, .mst_phase_in,
   .slv_read_cmd_in, .txfifo_not_empty_in, .abort_cause_out, .transmit_abort_event_out,
   .master_abort_out, .slave_abort_out, .txfifo_flush_out);

/* verif/tb.sv */
// Self-checking bench of the transmit abort cause block
`timescale 1ns/1ps
`include "itas_defs.svh"
module tb;
   logic clk_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [31:0] avs_address_in = 32'h0, avs_writedata_in = 32'h0, avs_readdata_out, rv;
   logic [3:0] avs_byteenable_in = 4'hF;
   logic avs_waitrequest_out, master_mode_enable_in = 1'b1, repeated_start_allow_in = 1'b1;
   logic gc_or_startbyte_request_in = 1'b0, general_call_vs_startbyte_select_in = 1'b0;
   logic tenbit_addr_in = 1'b0, highspeed_mode_in = 1'b0, mst_next_read_in = 1'b0;
   logic slave_read_service_in = 1'b0, txfifo_not_empty_in = 1'b0, mst_ack_seen_in = 1'b0;
   logic mst_start_req_in = 1'b0, mst_ack_sample_in = 1'b0, data_cmd_write_in = 1'b0;
   logic slv_read_cmd_in = 1'b0, mst_tx_active_in = 1'b0, slv_tx_active_in = 1'b0;
   logic sda_drive_low_in = 1'b0, scl_in, sda_in, sda_out, sda_oe_out, scl_level_out;
   logic [9:0] data_cmd_in = 10'h0;
   itas_pkg::itas_phase_e mst_phase_in = itas_pkg::ITAS_PH_ADDR7;
   logic [15:0] abort_cause_out;
   logic transmit_abort_event_out, master_abort_out, slave_abort_out, txfifo_flush_out;
   logic frame = 1'b0, pull_low = 1'b0;
   int fail_count = 0, checks = 0, cyc = 0;
   itas_top itas_top_i (.clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
      .master_mode_enable_in, .repeated_start_allow_in, .gc_or_startbyte_request_in,
      .general_call_vs_startbyte_select_in, .tenbit_addr_in, .highspeed_mode_in,
      .mst_start_req_in, .mst_next_read_in, .mst_ack_sample_in, .mst_ack_seen_in,
      .mst_phase_in, .mst_tx_active_in, .slave_read_service_in, .data_cmd_write_in,
      .data_cmd_in, .slv_read_cmd_in, .txfifo_not_empty_in, .slv_tx_active_in,
      .sda_drive_low_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .abort_cause_out,
      .transmit_abort_event_out, .master_abort_out, .slave_abort_out, .txfifo_flush_out,
      .scl_level_out);
   itas_remote itas_remote_i (.frame_in(frame), .pull_low_in(pull_low),
      .dev_oe_in(sda_oe_out), .scl_out(scl_in), .sda_out(sda_in));
   // 200 MHz clock
   always #2.5 clk_in = ~clk_in;
   // Hang guard, well above the fewer than one thousand cycles the run needs
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One bus cycle; request held until waitrequest is seen low
   task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_read_in <= !we;
      avs_write_in <= we;
      avs_address_in <= a;
      avs_writedata_in <= d;
      do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
      rv = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input string n, input logic [31:0] a, input logic [15:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, {16'h0, e}, rv);
   endtask
   // Levels, then a one-cycle pulse, then read and clear the cause register
   task automatic cause(input string n, input logic [10:0] lv, input logic [3:0] pu,
         input itas_pkg::itas_phase_e ph, input logic [15:0] e);
      @(posedge clk_in);
      {master_mode_enable_in, repeated_start_allow_in, gc_or_startbyte_request_in,
         general_call_vs_startbyte_select_in, tenbit_addr_in, highspeed_mode_in,
         mst_next_read_in, slave_read_service_in, txfifo_not_empty_in,
         mst_ack_seen_in} <= lv[10:1];
      data_cmd_in <= {1'b0, lv[0], 8'h5A};
      mst_phase_in <= ph;
      @(posedge clk_in);
      {mst_start_req_in, mst_ack_sample_in, data_cmd_write_in, slv_read_cmd_in} <= pu;
      @(posedge clk_in);
      {mst_start_req_in, mst_ack_sample_in, data_cmd_write_in, slv_read_cmd_in} <= 4'h0;
      rdchk(n, `ITAS_OFS_ABRT_SRC, e);
      rdchk("clear", `ITAS_OFS_ABRT_CLR, 16'h0);
      $display("done %s", n);
   endtask
   // Frame of SCL while roles transmit; remote may contradict the released SDA
   task automatic loss(input string n, input logic m, input logic s, input logic pl,
         input logic [15:0] e);
      @(posedge clk_in);
      mst_tx_active_in <= m;
      slv_tx_active_in <= s;
      pull_low <= pl;
      frame <= 1'b1;
      repeat (80) @(posedge clk_in);
      frame <= 1'b0;
      repeat (40) @(posedge clk_in);
      {mst_tx_active_in, slv_tx_active_in, pull_low} <= 3'h0;
      rdchk(n, `ITAS_OFS_ABRT_SRC, e);
      rdchk("clear", `ITAS_OFS_ABRT_CLR, 16'h0);
      $display("done %s", n);
   endtask
   // Device pulls SDA low; its output enable follows SCL's fall by the hold count
   task automatic hold_test(input logic [15:0] h);
      int n = 0;
      bus(1'b1, `ITAS_OFS_SDA_HOLD, {16'h0000, h});
      sda_drive_low_in <= 1'b1;
      frame <= 1'b1;
      do @(posedge clk_in); while (scl_level_out !== 1'b0);
      do begin
         @(posedge clk_in);
         n++;
      end while (sda_oe_out !== 1'b1 && n < 64);
      frame <= 1'b0;
      sda_drive_low_in <= 1'b0;
      chk("hold delay", {16'h0000, h}, n);
      chk("sda out", 32'h0, {31'h0, sda_out});
      $display("done hold");
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rdchk("hold reset", `ITAS_OFS_SDA_HOLD, `ITAS_RST_SDA_HOLD);
      rdchk("abort reset", `ITAS_OFS_ABRT_SRC, `ITAS_RST_ABRT_SRC);
      bus(1'b1, `ITAS_OFS_SDA_HOLD, 32'h0000A5C3);
      rdchk("hold rw", `ITAS_OFS_SDA_HOLD, 16'hA5C3);
      // Short hold so the sequencer is not left waiting through the frames
      bus(1'b1, `ITAS_OFS_SDA_HOLD, 32'h00000004);
      bus(1'b1, `ITAS_OFS_ABRT_SRC, 32'h0000FFFF);
      rdchk("abort ro", `ITAS_OFS_ABRT_SRC, 16'h0);
      rdchk("unmapped", 32'h50001384, 16'h0);
      cause("addr7", 11'h600, 4'h4, itas_pkg::ITAS_PH_ADDR7, 16'h0001);
      cause("addr10 1", 11'h640, 4'h4, itas_pkg::ITAS_PH_ADDR10_1, 16'h0002);
      cause("addr10 2", 11'h640, 4'h4, itas_pkg::ITAS_PH_ADDR10_2, 16'h0004);
      cause("data", 11'h600, 4'h4, itas_pkg::ITAS_PH_DATA, 16'h0008);
      cause("gcall nack", 11'h600, 4'h4, itas_pkg::ITAS_PH_GCALL, 16'h0010);
      cause("gcall read", 11'h612, 4'h4, itas_pkg::ITAS_PH_GCALL, 16'h0020);
      cause("sbyte ack", 11'h602, 4'h4, itas_pkg::ITAS_PH_SBYTE, 16'h0080);
      cause("hs ack", 11'h622, 4'h4, itas_pkg::ITAS_PH_HSCODE, 16'h0040);
      cause("mst off", 11'h200, 4'h8, itas_pkg::ITAS_PH_ADDR7, 16'h0800);
      cause("10b read", 11'h450, 4'h8, itas_pkg::ITAS_PH_ADDR7, 16'h0400);
      cause("hs norestart", 11'h420, 4'h8, itas_pkg::ITAS_PH_ADDR7, 16'h0100);
      cause("slv cmd", 11'h609, 4'h2, itas_pkg::ITAS_PH_ADDR7, 16'h8000);
      cause("slv data", 11'h608, 4'h2, itas_pkg::ITAS_PH_ADDR7, 16'h0000);
      cause("stale fifo", 11'h604, 4'h1, itas_pkg::ITAS_PH_ADDR7, 16'h2000);
      cause("sbyte norestart", 11'h580, 4'h8, itas_pkg::ITAS_PH_ADDR7, 16'h0200);
      cause("sbyte fixed", 11'h600, 4'h0, itas_pkg::ITAS_PH_ADDR7, 16'h0200);
      rdchk("after fix", `ITAS_OFS_ABRT_SRC, 16'h0);
      loss("mst loss", 1'b1, 1'b0, 1'b1, 16'h1000);
      loss("slv loss", 1'b0, 1'b1, 1'b1, 16'h5000);
      loss("both loss", 1'b1, 1'b1, 1'b1, 16'h5000);
      loss("no loss", 1'b1, 1'b1, 1'b0, 16'h0000);
      hold_test(16'h0003);
      stop_test();
   end
endmodule
